/* File: hw/spme_pkg.sv */
// Package of constants and types for the serial program mode entry block
package spme_pkg;
  // ==========================================================================
  // Key and link geometry
  localparam int          SPME_KEY_BITS  = 32;
  localparam logic [31:0] SPME_KEY_RESET = 32'h0000_0000;
  localparam logic [5:0]  SPME_CNT_RESET = 6'h00;
  localparam int          SPME_SYNC_STAGES = 2;
  // Default key value is arbitrary; the real key is set by a parameter
  localparam logic [31:0] SPME_KEY_DEFAULT = 32'h5A3C_96E1;

  // ==========================================================================
  // Entry modes
  typedef enum logic [1:0] {
    SPME_NORMAL,
    SPME_HV_SESSION,
    SPME_LV_SESSION
  } spme_mode_t;
endpackage

/* File: hw/spme_sync.sv */
// Two-stage synchroniser for pin inputs, one bit per lane
`timescale 1ns/10ps
`default_nettype none
module spme_sync
  import spme_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  // ==========================================================================
  // Synchroniser stages
  logic [WIDTH-1:0] meta_r;

  // First stage is read only by the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: hw/spme_top.sv */
// Program/verify mode entry logic: high-voltage and keyed low-voltage entry
// Function
// - The data pin is two-way serial data; the clock pin is only an input.
// - Low-voltage entry is accepted only while the enable bit is 1.
// - While the enable bit is set, the clear reset function is forced on.
// - The enable bit may be cleared only in a high-voltage session.
// - In the mode, memory, IDs and configuration go over the link.
`timescale 1ns/10ps
`default_nettype none
module spme_top
  import spme_pkg::*;
#(
  parameter logic [31:0] ENTRY_KEY = SPME_KEY_DEFAULT,
  parameter int          KEY_BITS  = SPME_KEY_BITS
) (
  input  wire logic MCLK_IN,
  input  wire logic ARST_N_IN,
  input  wire logic PROG_CLOCK_PIN_IN,
  input  wire logic PROG_DATA_PIN_IN,
  input  wire logic MASTER_CLEAR_N_PIN_IN,
  input  wire logic HIGH_PROG_VOLTAGE_IN,
  input  wire logic LOW_VOLTAGE_ENTRY_ENABLE_IN,
  input  wire logic CLEAR_RESET_CFG_IN,
  input  wire logic LINK_DATA_OUT_IN,
  input  wire logic LINK_DATA_OE_IN,
  input  wire logic CLEAR_LV_ENABLE_REQ_IN,
  output logic      PROG_DATA_PIN_OUT,
  output logic      PROG_DATA_PIN_OE_OUT,
  output logic      PROG_MODE_OUT,
  output logic      HV_SESSION_OUT,
  output logic      LINK_CLOCK_RISE_OUT,
  output logic      LINK_DATA_OUT,
  output logic      MASTER_CLEAR_RESET_EN_OUT,
  output logic      CLEAR_LV_ENABLE_GRANT_OUT
);
  // ==========================================================================
  // Reset release
  logic rst_s1_r;
  logic rst_n_r;

  // Asynchronous assert, two-flop release
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_s1_r <= 1'h0;
      rst_n_r  <= 1'h0;
    end else begin
      rst_s1_r <= 1'h1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================================
  // Pin synchronisation
  logic [4:0] pins_s;
  logic       clk_s;
  logic       dat_s;
  logic       clr_n_s;
  logic       hv_s;
  logic       lve_s;
  logic [SPME_SYNC_STAGES-1:0] warm_r;

  spme_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_in   (MCLK_IN),
    .rst_n_in (rst_n_r),
    .d_in     ({PROG_CLOCK_PIN_IN, PROG_DATA_PIN_IN, MASTER_CLEAR_N_PIN_IN,
                HIGH_PROG_VOLTAGE_IN, LOW_VOLTAGE_ENTRY_ENABLE_IN}),
    .q_out    (pins_s)
  );

  assign clk_s    = pins_s[4];
  assign dat_s    = pins_s[3];
  assign clr_n_s  = pins_s[2];
  assign hv_s     = pins_s[1];
  assign lve_s    = pins_s[0];

  // Fills with ones as the synchronisers fill with real pin levels; until
  // then their reset zeros must not read as a cleared enable bit
  always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      warm_r <= '0;
    end else begin
      warm_r <= {warm_r[SPME_SYNC_STAGES-2:0], 1'h1};
    end
  end

  // ==========================================================================
  // Link clock edge detection
  logic clk_d_r;
  logic clk_rise;

  // Clock pin is only sampled, never driven: it times each bit
  always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_d_r <= 1'h0;
    end else begin
      clk_d_r <= clk_s;
    end
  end

  assign clk_rise = clk_s & ~clk_d_r;

  // ==========================================================================
  // Key shifter
  logic [31:0] key_r;
  logic [5:0]  cnt_r;
  logic        lv_arm;
  logic        key_match;
  spme_mode_t  mode_r;

  // Keyed entry only counts while master clear is low and no session runs
  assign lv_arm    = lve_s & ~clr_n_s & ~hv_s & (mode_r == SPME_NORMAL);
  assign key_match = (key_r == ENTRY_KEY) && (cnt_r == 6'(KEY_BITS));

  // One bit per rising link clock, msb first; released clear wipes it
  always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      key_r <= SPME_KEY_RESET;
      cnt_r <= SPME_CNT_RESET;
    end else if (!lv_arm) begin
      key_r <= SPME_KEY_RESET;
      cnt_r <= SPME_CNT_RESET;
    end else if (clk_rise && cnt_r != 6'(KEY_BITS)) begin
      key_r <= {key_r[30:0], dat_s};
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // ==========================================================================
  // Mode state machine
  // High voltage wins over a key in progress, since it is the recovery path
  always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= SPME_NORMAL;
    end else begin
      unique case (mode_r)
        SPME_NORMAL: begin
          if (hv_s) begin
            mode_r <= SPME_HV_SESSION;
          end else if (lve_s && !clr_n_s && key_match) begin
            mode_r <= SPME_LV_SESSION;
          end
        end
        SPME_HV_SESSION: begin
          if (!hv_s) begin
            mode_r <= SPME_NORMAL;
          end
        end
        SPME_LV_SESSION: begin
          if (clr_n_s) begin
            mode_r <= SPME_NORMAL;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs, all registered
  always_ff @(posedge MCLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PROG_MODE_OUT             <= 1'h0;
      HV_SESSION_OUT            <= 1'h0;
      LINK_CLOCK_RISE_OUT       <= 1'h0;
      LINK_DATA_OUT             <= 1'h0;
      PROG_DATA_PIN_OUT         <= 1'h0;
      PROG_DATA_PIN_OE_OUT      <= 1'h0;
      MASTER_CLEAR_RESET_EN_OUT <= 1'h1;
      CLEAR_LV_ENABLE_GRANT_OUT <= 1'h0;
    end else begin
      PROG_MODE_OUT  <= (mode_r != SPME_NORMAL);
      HV_SESSION_OUT <= (mode_r == SPME_HV_SESSION);
      // Link strobes reach the command logic only inside a session
      LINK_CLOCK_RISE_OUT <= clk_rise & (mode_r != SPME_NORMAL);
      LINK_DATA_OUT       <= dat_s;
      // Data pin turns around only in a session
      PROG_DATA_PIN_OUT    <= LINK_DATA_OUT_IN;
      PROG_DATA_PIN_OE_OUT <= LINK_DATA_OE_IN & (mode_r != SPME_NORMAL);
      // Enable bit set forces the clear pin reset on; held on while the
      // synchronisers warm up, so no false off follows a reset
      MASTER_CLEAR_RESET_EN_OUT <= lve_s | CLEAR_RESET_CFG_IN |
                                   ~warm_r[SPME_SYNC_STAGES-1];
      // Clearing the enable bit needs a high-voltage session
      CLEAR_LV_ENABLE_GRANT_OUT <= CLEAR_LV_ENABLE_REQ_IN &
                                   (mode_r == SPME_HV_SESSION);
    end
  end

  // ==========================================================================
  // Checks
  chk_lv_needs_enable: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    (mode_r == SPME_NORMAL ##1 mode_r == SPME_LV_SESSION) |-> $past(lve_s))
    else $error("low-voltage entry without enable bit");

  chk_clear_forced_on: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    lve_s |=> MASTER_CLEAR_RESET_EN_OUT)
    else $error("clear reset not forced on");

  chk_clear_grant_hv: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    CLEAR_LV_ENABLE_GRANT_OUT |-> $past(mode_r) == SPME_HV_SESSION)
    else $error("enable cleared outside high-voltage session");

  chk_key_count: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    (lv_arm && clk_rise && cnt_r < 6'(KEY_BITS)) |=>
      cnt_r == $past(cnt_r) + 6'h01)
    else $error("key bit not counted");

  chk_full_key_entry: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    (mode_r == SPME_NORMAL ##1 mode_r == SPME_LV_SESSION) |->
      $past(cnt_r) == 6'(KEY_BITS))
    else $error("entry before full key");

  chk_release_exits: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    (mode_r == SPME_LV_SESSION && clr_n_s) |=> ##1 !PROG_MODE_OUT)
    else $error("mode kept after clear release");

  chk_release_wipes: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    clr_n_s |=> cnt_r == SPME_CNT_RESET)
    else $error("partial key kept");

  chk_oe_in_session: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    PROG_DATA_PIN_OE_OUT |-> $past(mode_r) != SPME_NORMAL)
    else $error("data pin driven outside session");

  chk_strobe_session: assert property (
    @(posedge MCLK_IN) disable iff (!rst_n_r)
    LINK_CLOCK_RISE_OUT |-> PROG_MODE_OUT || $past(mode_r) != SPME_NORMAL)
    else $error("link strobe outside session");
endmodule
`default_nettype wire

/* File: verif/spme_prog_model.sv */
// Programmer model: drives link clock, data, master clear and high voltage
`timescale 1ns/10ps
`default_nettype none
module spme_prog_model (
  input  wire logic clk_in,
  output logic      pclk_out,
  output logic      pdat_out,
  output logic      clr_n_out,
  output logic      hv_out
);
  // ==========================================================================
  // Idle: clock stands low outside frames, clear released
  initial begin
    pclk_out  = 1'h0;
    pdat_out  = 1'h0;
    clr_n_out = 1'h1;
    hv_out    = 1'h0;
  end
  // Clock and data held low before the high voltage moves
  task automatic hv(input logic on);
    @(negedge clk_in);
    pclk_out = 1'b0;
    pdat_out = 1'b0;
    repeat (2) @(negedge clk_in);
    hv_out = on;
    repeat (8) @(negedge clk_in);
  endtask
  // Clear low first, then n key bits msb first; 160 ns link clock period,
  // data moved in the middle of the low half
  task automatic key(input logic [31:0] k, input int n);
    @(negedge clk_in);
    clr_n_out = 1'h0;
    for (int i = 31; i > 31 - n; i--) begin
      repeat (2) @(negedge clk_in);
      pdat_out = k[i];
      repeat (2) @(negedge clk_in);
      pclk_out = 1'h1;
      repeat (4) @(negedge clk_in);
      pclk_out = 1'h0;
    end
    pdat_out = ~pdat_out; // Released data must not show the last bit
    repeat (8) @(negedge clk_in);
  endtask
  // Releasing the clear pin ends the session
  task automatic clear;
    @(negedge clk_in);
    clr_n_out = 1'h1;
    repeat (8) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_spme_top.sv */
// Self-checking bench for program mode entry
`timescale 1ns/10ps
`default_nettype none
module tb_spme_top;
  import spme_pkg::*;
  localparam logic [31:0] KEY = 32'hC3A5_0F96; // Arbitrary test key
  logic mclk, arst_n, lv_en, cfg, ldo, ldoe, req, pclk, pdat, clr_n, hv;
  logic dout, doe, mode, hvs, rise, ldat, rst_en, grant;
  int   errors, cmp_count, cycles, rise_cnt;
  wire  dpin = doe ? dout : pdat; // Pin level from both drivers
  spme_top #(.ENTRY_KEY(KEY)) i_dut (
    .MCLK_IN(mclk), .ARST_N_IN(arst_n), .PROG_CLOCK_PIN_IN(pclk),
    .PROG_DATA_PIN_IN(dpin), .MASTER_CLEAR_N_PIN_IN(clr_n),
    .HIGH_PROG_VOLTAGE_IN(hv), .LOW_VOLTAGE_ENTRY_ENABLE_IN(lv_en),
    .CLEAR_RESET_CFG_IN(cfg), .LINK_DATA_OUT_IN(ldo),
    .LINK_DATA_OE_IN(ldoe), .CLEAR_LV_ENABLE_REQ_IN(req),
    .PROG_DATA_PIN_OUT(dout), .PROG_DATA_PIN_OE_OUT(doe),
    .PROG_MODE_OUT(mode), .HV_SESSION_OUT(hvs), .LINK_CLOCK_RISE_OUT(rise),
    .LINK_DATA_OUT(ldat), .MASTER_CLEAR_RESET_EN_OUT(rst_en),
    .CLEAR_LV_ENABLE_GRANT_OUT(grant));
  spme_prog_model i_prog (.clk_in(mclk), .pclk_out(pclk), .pdat_out(pdat),
    .clr_n_out(clr_n), .hv_out(hv));
  // ==========================================================================
  // Clock, and a ceiling well above the 1600 or so cycles needed
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_n(input string nm, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Counts link strobes; a one-cycle pulse is caught at the next edge
  always @(posedge mclk) begin
    if (rise === 1'h1) begin
      rise_cnt++;
    end
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_lv_ok;
    int r0;
    i_prog.key(KEY, 32);
    chk("lv_mode", 1'b1, mode);
    chk("lv_hvs", 1'b0, hvs);
    chk("link_data", pdat, ldat);
    r0 = rise_cnt;
    i_prog.key(KEY, 2);
    chk_n("lv_rise", r0 + 2, rise_cnt);
    chk("link_data2", pdat, ldat);
    req = 1'b1;
    ldo = 1'b1;
    ldoe = 1'b1;
    wt(3);
    chk("lv_grant", 1'b0, grant);
    chk("pin_oe", 1'b1, doe);
    chk("pin_out", 1'b1, dout);
    req = 1'b0;
    ldoe = 1'b0;
    i_prog.clear;
    chk("lv_exit", 1'b0, mode);
    $display("test lv_ok done");
  endtask
  // Wrong key and a cut-short key both leave the device in normal mode
  task automatic t_bad;
    int r0;
    r0 = rise_cnt;
    i_prog.key(KEY ^ 32'h0000_0001, 32);
    chk("bad_key", 1'b0, mode);
    i_prog.clear;
    i_prog.key(KEY, 16);
    chk("short_key", 1'h0, mode);
    i_prog.clear;
    i_prog.key(KEY, 32);
    chk("restart", 1'b1, mode);
    chk_n("idle_rise", r0, rise_cnt);
    i_prog.clear;
    $display("test bad_key done");
  endtask
  // Reset in mid-session drops the mode; the clear reset stays forced on
  task automatic t_rst;
    i_prog.key(KEY, 32);
    chk("pre_rst", 1'h1, mode);
    arst_n = 1'h0;
    wt(1);
    chk("rst_drop", 1'h0, mode);
    arst_n = 1'h1;
    repeat (8) begin
      wt(1);
      chk("rst_en_warm", 1'h1, rst_en);
    end
    chk("rst_no_key", 1'h0, mode);
    i_prog.clear;
    $display("test rst done");
  endtask
  task automatic t_lv_off;
    lv_en = 1'b0;
    wt(4);
    chk("rst_en_off", 1'b0, rst_en);
    cfg = 1'b1;
    wt(4);
    chk("rst_en_cfg", 1'b1, rst_en);
    i_prog.key(KEY, 32);
    chk("lv_refused", 1'b0, mode);
    i_prog.clear;
    lv_en = 1'b1;
    cfg = 1'b0;
    wt(4);
    chk("rst_en_on", 1'b1, rst_en);
    $display("test lv_off done");
  endtask
  task automatic t_hv;
    i_prog.hv(1'b1);
    chk("hv_mode", 1'b1, mode);
    chk("hv_sess", 1'b1, hvs);
    req = 1'b1;
    wt(3);
    chk("hv_grant", 1'b1, grant);
    req = 1'b0;
    i_prog.hv(1'b0);
    chk("hv_exit", 1'b0, mode);
    $display("test hv done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {mclk, arst_n, cfg, ldo, ldoe, req} = 6'h00;
    lv_en = 1'b1;
    {errors, cmp_count, cycles} = {32'h0, 32'h0, 32'h0};
    wt(5);
    arst_n = 1'b1;
    chk("rst_mode", 1'b0, mode);
    chk("rst_en", 1'b1, rst_en);
    repeat (8) begin
      wt(1);
      chk("rst_en_start", 1'h1, rst_en);
    end
    t_lv_ok;
    t_bad;
    t_rst;
    t_lv_off;
    t_hv;
    print_verdict;
  end
endmodule
`default_nettype wire
